/* verilog/eip_irq_front.sv */
// Purpose: Edge detection, pending latch, acknowledge and number output.
// Assumes: Core pulses svc_take_i for one cycle when it takes the interrupt
//          shown on svc_req_o/svc_num_o; pins are asynchronous.
// Notes:   Sources 2,3,8..15 come from on-chip peripherals as pulses.
`timescale 1ns/1ps
`default_nettype none
`include "eip_defs.svh"
module eip_irq_front
    import eip_pkg::*;
#(
    parameter int ACK_CYCLES = 1
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    input  wire logic [`EIP_EXT_CNT-1:0]   external_irq_in_i,
    input  wire logic [`EIP_EXT_CNT-1:0]   ext_irq_edge_polarity_i,
    input  wire logic                      nmi_in_i,
    input  wire logic [`EIP_NUM_IRQS-1:0]  int_event_i,
    input  wire logic [`EIP_NUM_IRQS-1:0]  irq_enable_i,
    input  wire logic                      svc_take_i,
    output logic                           svc_req_o,
    output logic [`EIP_NUM_W-1:0]          svc_num_o,
    output logic [`EIP_NUM_IRQS-1:0]       pending_o,
    output logic                           irq_service_ack_out_o,
    output logic [`EIP_NUM_W-1:0]          serviced_irq_number_o
);
    // ============================================================
    // Pin synchronisers
    logic [`EIP_EXT_CNT:0] meta_q, sync_q, prev_q;
    logic [`EIP_EXT_CNT:0] pins, edge_hit;
    logic [`EIP_EXT_CNT:0] meta_d, sync_d, prev_d;

    assign pins = {nmi_in_i, external_irq_in_i};

    always_comb begin
        meta_d = pins;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ============================================================
    // Edge detection
    genvar gi;
    generate
        for (gi = 0; gi < `EIP_EXT_CNT; gi++) begin : g_ext
            assign edge_hit[gi] = ext_irq_edge_polarity_i[gi]
                                ? (prev_q[gi] & ~sync_q[gi])
                                : (~prev_q[gi] & sync_q[gi]);
        end
    endgenerate
    assign edge_hit[`EIP_EXT_CNT] = ~prev_q[`EIP_EXT_CNT] & sync_q[`EIP_EXT_CNT];

    // ============================================================
    // Pending events and priority pick
    logic [`EIP_NUM_IRQS-1:0] pend_q, pend_d, raw_evt, eligible;
    logic                     found;
    logic [`EIP_NUM_W-1:0]    pick;

    always_comb begin
        raw_evt = int_event_i;
        raw_evt[`EIP_NUM_RESET] = 1'b0;
        // number 1 is the nonmaskable pin
        raw_evt[`EIP_NUM_NMI] = edge_hit[`EIP_EXT_CNT];
        for (int k = 0; k < `EIP_EXT_CNT; k++) begin
            raw_evt[`EIP_EXT_BASE + k] = edge_hit[k];
        end
    end

    always_comb begin
        eligible = pend_q & irq_enable_i;
        eligible[`EIP_NUM_FIXED-1:0] = pend_q[`EIP_NUM_FIXED-1:0];
        found = 1'b0;
        pick  = '0;
        for (int k = `EIP_NUM_IRQS - 1; k >= 0; k--) begin
            if (eligible[k]) begin
                found = 1'b1;
                pick  = k[`EIP_NUM_W-1:0];
            end
        end
    end

    // ============================================================
    // Service sequencing
    eip_state_t st_q, st_d;
    eip_ack_t   out_q, out_d;
    logic [7:0] cnt_q, cnt_d;
    logic       take;

    assign take = svc_take_i & found & (st_q == EIP_IDLE);

    always_comb begin
        pend_d = pend_q;
        if (take) begin
            pend_d[pick] = 1'b0;
        end
        pend_d = pend_d | raw_evt;
        st_d  = st_q;
        out_d = out_q;
        cnt_d = cnt_q;
        case (st_q)
            EIP_IDLE: begin
                if (take) begin
                    st_d      = EIP_ACK;
                    out_d.ack = 1'b1;
                    out_d.num = pick;
                    cnt_d     = 8'(ACK_CYCLES - 1);
                end
            end
            EIP_ACK: begin
                if (cnt_q == 8'h00) begin
                    st_d      = EIP_IDLE;
                    out_d.ack = 1'b0;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                st_d  = EIP_IDLE;
                out_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pend_q <= '0;
            st_q   <= EIP_IDLE;
            out_q  <= '0;
            cnt_q  <= 8'h00;
        end else begin
            pend_q <= pend_d;
            st_q   <= st_d;
            out_q  <= out_d;
            cnt_q  <= cnt_d;
        end
    end

    assign svc_req_o             = found & (st_q == EIP_IDLE);
    assign svc_num_o             = pick;
    assign pending_o             = pend_q;
    assign irq_service_ack_out_o = out_q.ack;
    assign serviced_irq_number_o = out_q.num;

    // ============================================================
    // Checks
    sequence s_take;
        svc_take_i && svc_req_o;
    endsequence

    property p_ack_follows;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_take |=> irq_service_ack_out_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("no ack after service");

    property p_num_match;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_take |=> serviced_irq_number_o == $past(svc_num_o);
    endproperty
    a_num_match: assert property (p_num_match) else $error("wrong serviced number");

    property p_num_stable;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        irq_service_ack_out_o |=> $stable(serviced_irq_number_o);
    endproperty
    a_num_stable: assert property (p_num_stable) else $error("number moved during ack");

    property p_nmi_pend;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (!prev_q[`EIP_EXT_CNT] && sync_q[`EIP_EXT_CNT]) |=> pend_q[`EIP_NUM_NMI];
    endproperty
    a_nmi_pend: assert property (p_nmi_pend) else $error("nmi edge lost");

    property p_ext_edge;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (edge_hit[0]) |=> pend_q[`EIP_EXT_BASE];
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("ext edge not pending");

    property p_priority;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (svc_req_o && pend_q[`EIP_NUM_NMI]) |-> svc_num_o <= `EIP_NUM_NMI;
    endproperty
    a_priority: assert property (p_priority) else $error("nmi not preferred");

    property p_ack_len;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(irq_service_ack_out_o) |-> ##[1:256] !irq_service_ack_out_o;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack stuck");

    property p_slot;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (svc_req_o && svc_num_o == 4'(`EIP_EXT_BASE)) |-> pend_q[`EIP_EXT_BASE];
    endproperty
    a_slot: assert property (p_slot) else $error("slot mismatch");

    property p_route;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        edge_hit[`EIP_EXT_CNT-1] |=> pend_q[`EIP_EXT_BASE + `EIP_EXT_CNT - 1];
    endproperty
    a_route: assert property (p_route) else $error("pin 7 misrouted");
endmodule : eip_irq_front
`default_nettype wire

/* verilog/eip_defs.svh */
// Purpose: Constants for the external interrupt pin front end.
// Assumes: Included by the package and the design module.
// Notes:   Numbers follow the service fetch-packet order.
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH
`define EIP_NUM_W      4
`define EIP_NUM_IRQS   16
`define EIP_EXT_CNT    4
`define EIP_NUM_RESET  4'h0
`define EIP_NUM_NMI    4'h1
`define EIP_EXT_BASE   4
`define EIP_NUM_FIXED  4
`define EIP_SEL_EXT4   5'h04
`define EIP_SEL_EXT7   5'h07
`endif

/* verilog/eip_pkg.sv */
// Purpose: Types for the external interrupt pin front end.
// Assumes: eip_defs.svh supplies the constants.
// Notes:   Ack and number travel together.
`include "eip_defs.svh"
package eip_pkg;
    typedef enum logic [1:0] {
        EIP_IDLE = 2'b01,
        EIP_ACK  = 2'b10
    } eip_state_t;

    typedef struct packed {
        logic                  ack;
        logic [`EIP_NUM_W-1:0] num;
    } eip_ack_t;
endpackage : eip_pkg

/* tb/eip_peer.sv */
// Purpose: Peripheral model that raises pin interrupts
// Assumes: Fire strobes last one cycle
// Notes:   Pulses are stretched so the synchronisers catch them
`timescale 1ns/1ps
`default_nettype none
module eip_peer
    import eip_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic [3:0] pol_i,
    input  wire logic [3:0] fire_i,
    input  wire logic       nmi_fire_i,
    input  wire logic       ack_i,
    input  wire logic [3:0] num_i,
    output logic [3:0]      pins_o,
    output logic            nmi_o,
    output logic [3:0]      seen_num_o
);
    // ==========================================
    // Pulse stretch and number capture
    logic [4:0] s1_q = 5'h00;
    logic [4:0] s2_q = 5'h00;
    logic [4:0] s3_q = 5'h00;
    logic [4:0] act;
    assign act = s1_q | s2_q | s3_q;
    assign pins_o = pol_i ^ act[3:0];
    assign nmi_o = act[4];
    always_ff @(posedge clk_sys_i) begin
        s1_q <= {nmi_fire_i, fire_i};
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (ack_i) begin
            seen_num_o <= num_i;
        end
    end
endmodule : eip_peer
`default_nettype wire

/* tb/ext_irq_pins_and_ack_bench.sv */
// Purpose: Self-checking bench for the interrupt pin front end
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Polarity only changes under reset, avoiding false edges
`timescale 1ns/1ps
`default_nettype none
module ext_irq_pins_and_ack_bench;
    import eip_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, take = 1'b0, nmi_fire = 1'b0;
    logic [3:0] pol = 4'h0, fire = 4'h0, pins, seen, snum, inum;
    logic nmi, req, ack;
    logic [15:0] ev = 16'h0000, en = 16'h0000, pend;
    int fail_count = 0, total_checks = 0;
    initial forever #25 clk_sys_i = ~clk_sys_i;
    eip_peer peer (.clk_sys_i(clk_sys_i), .pol_i(pol), .fire_i(fire), .nmi_fire_i(nmi_fire),
        .ack_i(ack), .num_i(inum), .pins_o(pins), .nmi_o(nmi), .seen_num_o(seen));
    eip_irq_front dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .external_irq_in_i(pins),
        .ext_irq_edge_polarity_i(pol), .nmi_in_i(nmi), .int_event_i(ev), .irq_enable_i(en),
        .svc_take_i(take), .svc_req_o(req), .svc_num_o(snum), .pending_o(pend),
        .irq_service_ack_out_o(ack), .serviced_irq_number_o(inum));
    // ==========================================
    // Shared tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t bit %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_num(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t number %h want %h", $time, got, exp);
        end
    endtask : chk_num
    task automatic do_reset();
        rstn_i = 1'b0;
        step(10);
        rstn_i = 1'b1;
        step(1);
    endtask : do_reset
    task automatic svc(input logic [3:0] exp);
        for (int i = 0; i < 30 && req !== 1'b1; i++) step(1);
        chk_bit(req, 1'b1);
        chk_num(snum, exp);
        take = 1'b1;
        step(1);
        take = 1'b0;
        chk_bit(ack, 1'b1);
        chk_num(inum, exp);
        chk_bit(pend[exp], 1'b0);
        step(1);
        chk_bit(ack, 1'b0);
        chk_num(seen, exp);
    endtask : svc
    task automatic quiet();
        for (int i = 0; i < 8; i++) begin
            step(1);
            chk_bit(req, 1'b0);
        end
    endtask : quiet
    // ==========================================
    // Scenarios
    task automatic t_pins();
        for (int p = 0; p < 2; p++) begin
            pol = p[0] ? 4'hF : 4'h0;
            do_reset();
            en = 16'h00F0;
            for (int k = 0; k < 4; k++) begin
                fire = 4'h1 << k;
                step(1);
                fire = 4'h0;
                svc(4'(4 + k));
                quiet();
            end
        end
    endtask : t_pins
    task automatic t_prio();
        en = 16'h0010;
        nmi_fire = 1'b1;
        fire = 4'h1;
        ev = 16'h0004;
        step(1);
        {nmi_fire, fire, ev} = 21'h000000;
        step(5);
        svc(4'h1);
        svc(4'h2);
        svc(4'h4);
        quiet();
    endtask : t_prio
    task automatic t_mask();
        en = 16'h0000;
        ev = 16'h8000;
        step(1);
        ev = 16'h0000;
        quiet();
        chk_bit(pend[15], 1'b1);
        en = 16'h8000;
        ev = 16'h8000;
        step(1);
        ev = 16'h0000;
        svc(4'hF);
        // Event in the take cycle must survive the clear
        ev = 16'h8000;
        step(1);
        take = 1'b1;
        step(1);
        {take, ev} = 17'h00000;
        chk_bit(ack, 1'b1);
        chk_bit(pend[15], 1'b1);
        svc(4'hF);
    endtask : t_mask
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        t_pins();
        t_prio();
        t_mask();
        tally_and_finish();
    end
endmodule : ext_irq_pins_and_ack_bench
`default_nettype wire
